// ==== rtl/pah_owner_decode.sv ====
`timescale 1ns/1ns
`default_nettype none
module pah_owner_decode (
   // Owner code
   input wire logic [3:0] code_in,
   // Decoded owner
   output pah_pkg::pah_owner_t owner_out
);
   import pah_pkg::*;

   // ---------------------------------------------------------------
   // Code decode, reserved codes fold onto first host
   // ---------------------------------------------------------------
   wire is_none = (code_in == CODE_UNASSIGNED);
   wire is_second = (code_in == CODE_SECOND_HOST);

   assign owner_out = is_none ? OWN_NONE :
                      is_second ? OWN_SECOND_HOST :
                      OWN_FIRST_HOST;
endmodule
`default_nettype wire

// ==== rtl/pah_pkg.sv ====
package pah_pkg;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_SET1_PORTS34_OWNER = 8'hD6;
   localparam logic [7:0] OFF_SET1_RESERVED_C = 8'hD7;
   localparam logic [7:0] OFF_SET1_RESERVED_D = 8'hD8;
   localparam logic [7:0] OFF_SET2_PORTS12_OWNER = 8'hD9;
   localparam logic [7:0] OFF_SET2_PORTS34_OWNER = 8'hDA;
   localparam logic [7:0] OFF_SET2_RESERVED_C = 8'hDB;
   localparam logic [7:0] OFF_SET2_RESERVED_D = 8'hDC;

   // ---------------------------------------------------------------
   // Fields, reset values and owner codes
   // ---------------------------------------------------------------
   localparam int HI_NIB_LSB = 4;
   localparam int LO_NIB_LSB = 0;
   localparam logic [7:0] OWNER_REG_RESET = 8'h00;
   localparam logic [7:0] RESERVED_READ = 8'h00;
   localparam logic [3:0] CODE_UNASSIGNED = 4'h0;
   localparam logic [3:0] CODE_FIRST_HOST = 4'h1;
   localparam logic [3:0] CODE_SECOND_HOST = 4'h2;
   localparam int NUM_PORTS = 4;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      OWN_NONE,
      OWN_FIRST_HOST,
      OWN_SECOND_HOST
   } pah_owner_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pah_reg_req_t;

endpackage

// ==== rtl/pah_port_assign.sv ====
`timescale 1ns/1ns
`default_nettype none
module pah_port_assign (
   // Clock and reset
   input wire logic SYS_CLK_IN,
   input wire logic RESET_IN,
   // Register access
   input wire pah_pkg::pah_reg_req_t REG_REQ_IN,
   output logic [7:0] REG_RDATA_OUT,
   output logic REG_RVALID_OUT,
   // Set selection and set-1 ports 1 and 2 owner codes
   input wire logic SET_SEL_IN,
   input wire logic [7:0] SET1_PORTS12_OWNER_IN,
   // Port connections
   output logic [3:0] PORT_TO_FIRST_OUT,
   output logic [3:0] PORT_TO_SECOND_OUT
);
   import pah_pkg::*;

   // ---------------------------------------------------------------
   // Set select synchroniser
   // ---------------------------------------------------------------
   logic sel_meta_q;
   logic sel_q;

   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         sel_meta_q <= 1'b0;
         sel_q <= 1'b0;
      end else begin
         sel_meta_q <= SET_SEL_IN;
         sel_q <= sel_meta_q;
      end
   end

   // ---------------------------------------------------------------
   // Register decode
   // ---------------------------------------------------------------
   logic [7:0] set1_ports34_owner_q;
   logic [7:0] set2_ports12_owner_q;
   logic [7:0] set2_ports34_owner_q;
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;
   logic rvalid_q;

   wire [7:0] addr = REG_REQ_IN.addr;
   wire hit_s1_p34 = (addr == OFF_SET1_PORTS34_OWNER);
   wire hit_s2_p12 = (addr == OFF_SET2_PORTS12_OWNER);
   wire hit_s2_p34 = (addr == OFF_SET2_PORTS34_OWNER);
   wire hit_rsvd = (addr == OFF_SET1_RESERVED_C) || (addr == OFF_SET1_RESERVED_D) ||
                   (addr == OFF_SET2_RESERVED_C) || (addr == OFF_SET2_RESERVED_D);
   wire wr_s1_p34 = REG_REQ_IN.wr && hit_s1_p34;
   wire wr_s2_p12 = REG_REQ_IN.wr && hit_s2_p12;
   wire wr_s2_p34 = REG_REQ_IN.wr && hit_s2_p34;

   assign rdata_d = hit_s1_p34 ? set1_ports34_owner_q :
                    hit_s2_p12 ? set2_ports12_owner_q :
                    hit_s2_p34 ? set2_ports34_owner_q :
                    hit_rsvd ? RESERVED_READ :
                    8'h00;

   // ---------------------------------------------------------------
   // Owner registers
   // ---------------------------------------------------------------
   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         set1_ports34_owner_q <= OWNER_REG_RESET;
         set2_ports12_owner_q <= OWNER_REG_RESET;
         set2_ports34_owner_q <= OWNER_REG_RESET;
      end else begin
         if (wr_s1_p34) begin
            set1_ports34_owner_q <= REG_REQ_IN.wdata;
         end
         if (wr_s2_p12) begin
            set2_ports12_owner_q <= REG_REQ_IN.wdata;
         end
         if (wr_s2_p34) begin
            set2_ports34_owner_q <= REG_REQ_IN.wdata;
         end
      end
   end

   // ---------------------------------------------------------------
   // Read return
   // ---------------------------------------------------------------
   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= REG_REQ_IN.rd;
         if (REG_REQ_IN.rd) begin
            rdata_q <= rdata_d;
         end
      end
   end

   assign REG_RDATA_OUT = rdata_q;
   assign REG_RVALID_OUT = rvalid_q;

   // ---------------------------------------------------------------
   // Active set selection
   // ---------------------------------------------------------------
   wire [7:0] act_p12 = sel_q ? set2_ports12_owner_q : SET1_PORTS12_OWNER_IN;
   wire [7:0] act_p34 = sel_q ? set2_ports34_owner_q : set1_ports34_owner_q;
   logic [3:0] port_code [NUM_PORTS];

   assign port_code[0] = act_p12[LO_NIB_LSB +: 4];
   assign port_code[1] = act_p12[HI_NIB_LSB +: 4];
   assign port_code[2] = act_p34[LO_NIB_LSB +: 4];
   assign port_code[3] = act_p34[HI_NIB_LSB +: 4];

   // ---------------------------------------------------------------
   // Per-port decode and routing
   // ---------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
         pah_owner_t owner;

         pah_owner_decode u_dec (
            .code_in(port_code[gi]),
            .owner_out(owner)
         );

         pah_port_route u_route (
            .clk_in(SYS_CLK_IN),
            .rst_in(RESET_IN),
            .owner_in(owner),
            .to_first_out(PORT_TO_FIRST_OUT[gi]),
            .to_second_out(PORT_TO_SECOND_OUT[gi])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   sequence s_write_s2_p34;
      REG_REQ_IN.wr && (REG_REQ_IN.addr == OFF_SET2_PORTS34_OWNER);
   endsequence

   sequence s_read_s2_p34;
      REG_REQ_IN.rd && !REG_REQ_IN.wr && (REG_REQ_IN.addr == OFF_SET2_PORTS34_OWNER);
   endsequence

   sequence s_write_s1_p34;
      REG_REQ_IN.wr && (REG_REQ_IN.addr == OFF_SET1_PORTS34_OWNER);
   endsequence

   sequence s_read_s1_p34;
      REG_REQ_IN.rd && !REG_REQ_IN.wr && (REG_REQ_IN.addr == OFF_SET1_PORTS34_OWNER);
   endsequence

   sequence s_write_s2_p12;
      REG_REQ_IN.wr && (REG_REQ_IN.addr == OFF_SET2_PORTS12_OWNER);
   endsequence

   sequence s_read_s2_p12;
      REG_REQ_IN.rd && !REG_REQ_IN.wr && (REG_REQ_IN.addr == OFF_SET2_PORTS12_OWNER);
   endsequence

   a_p4_owner_code: assert property (
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (sel_q && set2_ports34_owner_q[7:4] == 4'h2)
      |=> (PORT_TO_SECOND_OUT[3] && !PORT_TO_FIRST_OUT[3]))
      else $error("Port 4 not routed to second host");

   a_p3_unassigned: assert property (
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (!sel_q && set1_ports34_owner_q[3:0] == 4'h0)
      |=> (!PORT_TO_SECOND_OUT[2] && !PORT_TO_FIRST_OUT[2]))
      else $error("Port 3 connected while unassigned");

   a_p2_first_host: assert property (
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (sel_q && set2_ports12_owner_q[7:4] == 4'h1)
      |=> (PORT_TO_FIRST_OUT[1] && !PORT_TO_SECOND_OUT[1]))
      else $error("Port 2 not routed to first host");

   a_p1_second_host: assert property (
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (sel_q && set2_ports12_owner_q[3:0] == 4'h2)
      |=> (PORT_TO_SECOND_OUT[0] && !PORT_TO_FIRST_OUT[0]))
      else $error("Port 1 not routed to second host");

   a_reserved_code_fold: assert property (
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (sel_q && set2_ports12_owner_q[3:0] >= 4'h3)
      |=> (PORT_TO_FIRST_OUT[0] && !PORT_TO_SECOND_OUT[0]))
      else $error("Reserved code did not act as first host");

   a_reserved_reads_zero: assert property (
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (REG_REQ_IN.rd && hit_rsvd)
      |=> (REG_RVALID_OUT && REG_RDATA_OUT == 8'h00))
      else $error("Reserved register read nonzero");

   a_reset_all_zero: assert property (
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      $fell(RESET_IN)
      |-> (set1_ports34_owner_q == 8'h00 && set2_ports12_owner_q == 8'h00 &&
           set2_ports34_owner_q == 8'h00 && PORT_TO_FIRST_OUT == 4'h0 &&
           PORT_TO_SECOND_OUT == 4'h0))
      else $error("Owner registers not zero after reset");

   a_p34_write_read: assert property (
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      s_write_s2_p34 ##1 s_read_s2_p34
      |=> (REG_RVALID_OUT && REG_RDATA_OUT == $past(REG_REQ_IN.wdata, 2)))
      else $error("Ports 3 and 4 register did not hold write");

   a_route_exclusive: assert property (
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      ($rose(sel_q) && set2_ports12_owner_q[7:4] == 4'h0)
      |=> (!PORT_TO_FIRST_OUT[1] && !PORT_TO_SECOND_OUT[1]
           && ((PORT_TO_FIRST_OUT & PORT_TO_SECOND_OUT) == 4'h0)))
      else $error("Port routing does not follow selected set");

   a_p4_first_host: assert property (
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (!sel_q && set1_ports34_owner_q[7:4] == 4'h1)
      |=> (PORT_TO_FIRST_OUT[3] && !PORT_TO_SECOND_OUT[3]))
      else $error("Port 4 not routed to first host");

   a_p4_unassigned: assert property (
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (!sel_q && set1_ports34_owner_q[7:4] == 4'h0)
      |=> (!PORT_TO_FIRST_OUT[3] && !PORT_TO_SECOND_OUT[3]))
      else $error("Port 4 connected while unassigned");

   a_p3_second_host: assert property (
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (sel_q && set2_ports34_owner_q[3:0] == 4'h2)
      |=> (PORT_TO_SECOND_OUT[2] && !PORT_TO_FIRST_OUT[2]))
      else $error("Port 3 not routed to second host");

   a_p3_first_host: assert property (
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (!sel_q && set1_ports34_owner_q[3:0] == 4'h1)
      |=> (PORT_TO_FIRST_OUT[2] && !PORT_TO_SECOND_OUT[2]))
      else $error("Port 3 not routed to first host");

   a_p2_unassigned: assert property (
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (sel_q && set2_ports12_owner_q[7:4] == 4'h0)
      |=> (!PORT_TO_FIRST_OUT[1] && !PORT_TO_SECOND_OUT[1]))
      else $error("Port 2 connected while unassigned");

   a_p2_second_host: assert property (
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (!sel_q && SET1_PORTS12_OWNER_IN[7:4] == 4'h2)
      |=> (PORT_TO_SECOND_OUT[1] && !PORT_TO_FIRST_OUT[1]))
      else $error("Port 2 not routed to second host");

   a_p1_first_host: assert property (
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (!sel_q && SET1_PORTS12_OWNER_IN[3:0] == 4'h1)
      |=> (PORT_TO_FIRST_OUT[0] && !PORT_TO_SECOND_OUT[0]))
      else $error("Port 1 not routed to first host");

   a_p1_unassigned: assert property (
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (!sel_q && SET1_PORTS12_OWNER_IN[3:0] == 4'h0)
      |=> (!PORT_TO_FIRST_OUT[0] && !PORT_TO_SECOND_OUT[0]))
      else $error("Port 1 connected while unassigned");

   a_p3_code_fold: assert property (
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (sel_q && set2_ports34_owner_q[3:0] >= 4'h3)
      |=> (PORT_TO_FIRST_OUT[2] && !PORT_TO_SECOND_OUT[2]))
      else $error("Reserved port 3 code did not act as first host");

   a_p4_code_fold: assert property (
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (!sel_q && set1_ports34_owner_q[7:4] >= 4'h3)
      |=> (PORT_TO_FIRST_OUT[3] && !PORT_TO_SECOND_OUT[3]))
      else $error("Reserved port 4 code did not act as first host");

   a_reserved_write_ignored: assert property (
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (REG_REQ_IN.wr && hit_rsvd)
      |=> ($stable(set1_ports34_owner_q) && $stable(set2_ports12_owner_q) &&
           $stable(set2_ports34_owner_q)))
      else $error("Reserved write changed an owner register");
   a_read_valid_pulse: assert property (
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      REG_REQ_IN.rd
      |=> REG_RVALID_OUT)
      else $error("Read not answered one cycle later");

   a_idle_no_valid: assert property (
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      !REG_REQ_IN.rd
      |=> !REG_RVALID_OUT)
      else $error("Read valid without a read");

   a_rdata_hold: assert property (
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      !REG_REQ_IN.rd
      |=> $stable(REG_RDATA_OUT))
      else $error("Read data changed without a read");

   a_set1_p34_hold: assert property (
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      s_write_s1_p34 ##1 s_read_s1_p34
      |=> (REG_RVALID_OUT && REG_RDATA_OUT == $past(REG_REQ_IN.wdata, 2)))
      else $error("Set 1 ports 3 and 4 register did not hold write");

   a_set2_p12_hold: assert property (
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      s_write_s2_p12 ##1 s_read_s2_p12
      |=> (REG_RVALID_OUT && REG_RDATA_OUT == $past(REG_REQ_IN.wdata, 2)))
      else $error("Set 2 ports 1 and 2 register did not hold write");

   a_reset_ports_clear: assert property (
      @(posedge SYS_CLK_IN)
      RESET_IN
      |=> (PORT_TO_FIRST_OUT == 4'h0 && PORT_TO_SECOND_OUT == 4'h0 && !REG_RVALID_OUT))
      else $error("Ports or read valid not cleared by reset");

endmodule
`default_nettype wire

// ==== rtl/pah_port_route.sv ====
`timescale 1ns/1ns
`default_nettype none
module pah_port_route (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Owner of this port
   input wire pah_pkg::pah_owner_t owner_in,
   // Connections
   output logic to_first_out,
   output logic to_second_out
);
   import pah_pkg::*;

   // ---------------------------------------------------------------
   // Connection switches
   // ---------------------------------------------------------------
   wire first_d = (owner_in == OWN_FIRST_HOST);
   wire second_d = (owner_in == OWN_SECOND_HOST);

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         to_first_out <= 1'b0;
         to_second_out <= 1'b0;
      end else begin
         to_first_out <= first_d;
         to_second_out <= second_d;
      end
   end
endmodule
`default_nettype wire

// ==== testbench/test_port_host_assignment_config.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_port_host_assignment_config;
   import pah_pkg::*;

   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   pah_reg_req_t req = '0;
   logic sel = 1'b0;
   logic [7:0] set1_codes = 8'h00;
   logic [7:0] rdata;
   logic rvalid;
   logic [3:0] to_first;
   logic [3:0] to_second;
   logic [3:0] code;
   int miscompares = 0;
   int comparisons = 0;

   always #5 sys_clk = ~sys_clk;

   pah_port_assign pah_port_assign_i (
      .SYS_CLK_IN(sys_clk),
      .RESET_IN(reset),
      .REG_REQ_IN(req),
      .REG_RDATA_OUT(rdata),
      .REG_RVALID_OUT(rvalid),
      .SET_SEL_IN(sel),
      .SET1_PORTS12_OWNER_IN(set1_codes),
      .PORT_TO_FIRST_OUT(to_first),
      .PORT_TO_SECOND_OUT(to_second)
   );

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic access(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      req = '{wr: w, rd: r, addr: a, wdata: d};
      cycles(1);
   endtask

   task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
      access(1'b0, 1'b1, a, 8'h00);
      check({7'h00, rvalid}, 8'h01);
      check(rdata, exp);
   endtask

   task automatic route_check(input logic [3:0] f, input logic [3:0] s);
      check({4'h0, to_first}, {4'h0, f});
      check({4'h0, to_second}, {4'h0, s});
   endtask

   // ---------------------------------------------------------------
   // Watchdog
   // ---------------------------------------------------------------
   initial begin
      #200000;
      miscompares++;
      final_report();
   end

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      cycles(8);
      reset = 1'b0;
      cycles(1);
      route_check(4'h0, 4'h0);
      read_check(OFF_SET1_PORTS34_OWNER, OWNER_REG_RESET);
      read_check(OFF_SET2_PORTS12_OWNER, OWNER_REG_RESET);
      read_check(OFF_SET2_PORTS34_OWNER, OWNER_REG_RESET);
      // Reserved and unmapped places ignore writes and read zero
      access(1'b1, 1'b0, OFF_SET1_RESERVED_C, 8'hFF);
      access(1'b1, 1'b0, OFF_SET1_RESERVED_D, 8'hA5);
      access(1'b1, 1'b0, OFF_SET2_RESERVED_C, 8'h5A);
      access(1'b1, 1'b0, OFF_SET2_RESERVED_D, 8'h3C);
      access(1'b1, 1'b0, 8'h10, 8'h77);
      read_check(OFF_SET1_RESERVED_C, RESERVED_READ);
      read_check(OFF_SET1_RESERVED_D, RESERVED_READ);
      read_check(OFF_SET2_RESERVED_C, RESERVED_READ);
      read_check(OFF_SET2_RESERVED_D, RESERVED_READ);
      read_check(8'h10, 8'h00);
      // Separate registers per set, each read right after its write
      access(1'b1, 1'b0, OFF_SET1_PORTS34_OWNER, 8'hC3);
      read_check(OFF_SET1_PORTS34_OWNER, 8'hC3);
      access(1'b1, 1'b0, OFF_SET2_PORTS12_OWNER, 8'h5E);
      read_check(OFF_SET2_PORTS12_OWNER, 8'h5E);
      access(1'b1, 1'b0, OFF_SET2_PORTS34_OWNER, 8'h96);
      read_check(OFF_SET2_PORTS34_OWNER, 8'h96);
      read_check(OFF_SET1_PORTS34_OWNER, 8'hC3);
      read_check(OFF_SET2_PORTS12_OWNER, 8'h5E);
      // Write and read in one cycle returns the old value
      access(1'b1, 1'b1, OFF_SET2_PORTS34_OWNER, 8'h21);
      check(rdata, 8'h96);
      read_check(OFF_SET2_PORTS34_OWNER, 8'h21);
      // Every code on every port of set 1
      for (int c = 0; c < 16; c++) begin
         code = c[3:0];
         set1_codes = {code, code};
         access(1'b1, 1'b0, OFF_SET1_PORTS34_OWNER, {code, code});
         cycles(2);
         if (code == CODE_UNASSIGNED) begin
            route_check(4'h0, 4'h0);
         end else if (code == CODE_SECOND_HOST) begin
            route_check(4'h0, 4'hF);
         end else begin
            route_check(4'hF, 4'h0);
         end
      end
      // Nibble placement in set 1
      set1_codes = 8'h21;
      access(1'b1, 1'b0, OFF_SET1_PORTS34_OWNER, 8'h12);
      cycles(2);
      route_check(4'b1001, 4'b0110);
      // Switch to set 2
      access(1'b1, 1'b0, OFF_SET2_PORTS12_OWNER, 8'h03);
      access(1'b1, 1'b0, OFF_SET2_PORTS34_OWNER, 8'h2B);
      sel = 1'b1;
      cycles(3);
      route_check(4'b0101, 4'b1000);
      // Rewrite set 2 while it is selected
      access(1'b1, 1'b0, OFF_SET2_PORTS12_OWNER, 8'h12);
      access(1'b1, 1'b0, OFF_SET2_PORTS34_OWNER, 8'h02);
      cycles(2);
      route_check(4'b0010, 4'b0101);
      // Back to set 1
      sel = 1'b0;
      cycles(3);
      route_check(4'b1001, 4'b0110);
      // Reset in mid-run clears the registers, then set-1 ports 1 and 2 codes are driven to zero
      req = '0;
      reset = 1'b1;
      cycles(2);
      reset = 1'b0;
      cycles(1);
      set1_codes = 8'h00;
      cycles(2);
      route_check(4'h0, 4'h0);
      read_check(OFF_SET1_PORTS34_OWNER, OWNER_REG_RESET);
      read_check(OFF_SET2_PORTS34_OWNER, OWNER_REG_RESET);
      final_report();
   end
endmodule
`default_nettype wire
